/* File: core/fc_regs.vh */
// Purpose: Register map, field positions and timing figures of the
//          frequency counting core.
// Assumes: 50 MHz system clock, 32-bit register data.
// Notes:   Definitions only.
`ifndef FC_REGS_VH
`define FC_REGS_VH

// ==========================================================
// Register byte offsets
`define FC_ADDR_W 5
`define FC_OFS_CTRL 5'h00
`define FC_OFS_RATIO 5'h04
`define FC_OFS_RESULT 5'h08
`define FC_OFS_STATUS 5'h0c
`define FC_OFS_MASK 5'h10

// ==========================================================
// Control fields
`define FC_CTRL_START 0
`define FC_CTRL_MEAS_LO 1
`define FC_CTRL_MEAS_HI 2
`define FC_CTRL_MW_SEL 3
`define FC_CTRL_HIZ 4
`define FC_CTRL_FAST 5
`define FC_CTRL_RES_KHZ 6
`define FC_CTRL_END_EDGE 7
`define FC_CTRL_W 8
`define FC_CTRL_RST 8'h00

// Measurement kinds
`define FC_MEAS_FREQ 2'h0
`define FC_MEAS_WIDTH 2'h1
`define FC_MEAS_PERIOD 2'h2

// ==========================================================
// Status / mask fields
`define FC_ST_DONE 0
`define FC_ST_OVERRUN 1
`define FC_ST_W 2
`define FC_ST_RST 2'h0
`define FC_MASK_RST 2'h0

// ==========================================================
// Ratio
`define FC_RATIO_W 30
`define FC_RATIO_MIN 30'h0000_0002
`define FC_RATIO_RST 30'h0000_0002

// ==========================================================
// Timing
`define FC_CLK_HZ 50000000
`define FC_GATE_1HZ_US 1000000
`define FC_GATE_1KHZ_US 1000

`endif

/* File: core/fc_cnt.v */
// Purpose: Clearable up counter used for gate time and event totals.
// Assumes: Single clock, asynchronous active-high reset.
// Notes:   Clear has priority over increment; wraps at full scale.
`timescale 1ns/10ps
`default_nettype none

module fc_cnt #(
    parameter WIDTH = 32
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire clr_i,
    input wire inc_i,
    output reg [WIDTH-1:0] cnt_o
);

    // ==========================================================
    // Counter
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_o <= {WIDTH{1'b0}};
        else if (clr_i)
            cnt_o <= {WIDTH{1'b0}};
        else if (inc_i)
            cnt_o <= cnt_o + {{(WIDTH-1){1'b0}}, 1'b1};
    end

endmodule // fc_cnt

`default_nettype wire

/* File: core/fc_core.v */
// Purpose: Counting core: direct, reciprocal, burst width and period.
// Assumes: Input pulses synchronous to clk_sys_i; one-cycle bus strobes.
// Notes:   Single-shot: each measurement starts by writing the start bit.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "fc_regs.vh"

module fc_core #(
    parameter WIDTH = 32,
    parameter GATE_LONG_CYC = (`FC_CLK_HZ / 1000000) * `FC_GATE_1HZ_US,
    parameter GATE_SHORT_CYC = (`FC_CLK_HZ / 1000000) * `FC_GATE_1KHZ_US
) (
    input wire clk_sys_i,
    input wire rst_i,
    // Register port
    input wire [`FC_ADDR_W-1:0] addr_i,
    input wire [31:0] wr_data_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rd_data_o,
    // Shaped inputs
    input wire low_band_input_i,
    input wire microwave_input_i,
    input wire burst_envelope_detector_i,
    // Status
    output reg gate_o,
    output reg irq_o
);

    // ==========================================================
    // States
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_ARM = 3'b010;
    localparam [2:0] ST_GATE = 3'b100;

    // ==========================================================
    // Declarations
    reg [`FC_CTRL_W-1:0] ctrl_r;
    reg [`FC_RATIO_W-1:0] ratio_r;
    reg [WIDTH-1:0] result_r;
    reg [`FC_ST_W-1:0] status_r;
    reg [`FC_ST_W-1:0] status_nxt;
    reg [`FC_ST_W-1:0] mask_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg sig_prev_r;
    reg env_prev_r;
    reg open_evt;
    reg close_evt;
    reg latch_evt;
    reg [WIDTH-1:0] latch_val;
    wire [1:0] meas;
    wire recip;
    wire sig_sel;
    wire sig_rise;
    wire env_rise;
    wire env_fall;
    wire per_edge;
    wire start;
    wire [WIDTH-1:0] gate_cnt;
    wire [WIDTH-1:0] ev_cnt;
    wire [WIDTH-1:0] gate_len;
    wire [WIDTH-1:0] ratio_eff;
    wire cnt_clr;
    wire [31:0] rd_mux;

    // ==========================================================
    // Decode helpers
    function hit;
        input [`FC_ADDR_W-1:0] a;
        input [`FC_ADDR_W-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    assign meas = ctrl_r[`FC_CTRL_MEAS_HI:`FC_CTRL_MEAS_LO];
    assign start = wr_i && hit(addr_i, `FC_OFS_CTRL) &&
                   wr_data_i[`FC_CTRL_START];

    // Method choice by input and setting
    assign recip = ctrl_r[`FC_CTRL_MW_SEL] ? ctrl_r[`FC_CTRL_FAST]
                                           : ctrl_r[`FC_CTRL_HIZ];

    // Microwave path carries the down-converted IF
    assign sig_sel = ctrl_r[`FC_CTRL_MW_SEL] ? microwave_input_i
                                             : low_band_input_i;

    // Edge detection; inputs are already synchronous
    assign sig_rise = sig_sel && !sig_prev_r;
    assign env_rise = burst_envelope_detector_i && !env_prev_r;
    assign env_fall = !burst_envelope_detector_i && env_prev_r;
    assign per_edge = ctrl_r[`FC_CTRL_END_EDGE] ? env_fall : env_rise;

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sig_prev_r <= 1'b0;
            env_prev_r <= 1'b0;
        end
        else
        begin
            sig_prev_r <= sig_sel;
            env_prev_r <= burst_envelope_detector_i;
        end
    end

    // Gate length by resolution, cast to counter width
    assign gate_len = ctrl_r[`FC_CTRL_RES_KHZ] ?
        GATE_SHORT_CYC[WIDTH-1:0] : GATE_LONG_CYC[WIDTH-1:0];

    // Ratios below the minimum are raised to it
    assign ratio_eff = (ratio_r < `FC_RATIO_MIN) ?
        {{(WIDTH-`FC_RATIO_W){1'b0}}, `FC_RATIO_MIN} :
        {{(WIDTH-`FC_RATIO_W){1'b0}}, ratio_r};

    // ==========================================================
    // Gate open/close conditions per measurement
    always @*
    begin
        open_evt = 1'b0;
        close_evt = 1'b0;
        latch_val = gate_cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        case (meas)
            `FC_MEAS_WIDTH:
            begin
                open_evt = env_rise;
                close_evt = env_fall;
            end
            `FC_MEAS_PERIOD:
            begin
                open_evt = per_edge;
                close_evt = per_edge;
            end
            default:
            begin
                if (recip)
                begin
                    // Gate starts on an input edge, ends after ratio cycles
                    open_evt = sig_rise;
                    close_evt = sig_rise &&
                        (ev_cnt + {{(WIDTH-1){1'b0}}, 1'b1} == ratio_eff);
                end
                else
                begin
                    // Fixed gate; total includes an edge in the last cycle
                    open_evt = 1'b1;
                    close_evt = (gate_cnt + {{(WIDTH-1){1'b0}}, 1'b1}
                                 == gate_len);
                    latch_val = ev_cnt +
                        {{(WIDTH-1){1'b0}}, sig_rise};
                end
            end
        endcase
    end

    // ==========================================================
    // Sequencer
    always @*
    begin
        state_nxt = state_r;
        latch_evt = 1'b0;
        case (state_r)
            ST_IDLE:
                if (start)
                    state_nxt = ST_ARM;
            ST_ARM:
                if (open_evt)
                    state_nxt = ST_GATE;
            ST_GATE:
                if (close_evt)
                begin
                    state_nxt = ST_IDLE;
                    latch_evt = 1'b1;
                end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // ==========================================================
    // Counters: cleared until the gate opens
    assign cnt_clr = (state_r != ST_GATE);

    fc_cnt #(
        .WIDTH(WIDTH)
    ) u_gate_cnt (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .clr_i(cnt_clr),
        .inc_i(1'b1),
        .cnt_o(gate_cnt)
    );

    // Counts shaped input edges inside the gate
    fc_cnt #(
        .WIDTH(WIDTH)
    ) u_ev_cnt (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .clr_i(cnt_clr),
        .inc_i(sig_rise),
        .cnt_o(ev_cnt)
    );

    // ==========================================================
    // Result holding register
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            result_r <= {WIDTH{1'b0}};
        else if (latch_evt)
            result_r <= latch_val;
    end

    // ==========================================================
    // Control, ratio and mask writes
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= `FC_CTRL_RST;
            ratio_r <= `FC_RATIO_RST;
            mask_r <= `FC_MASK_RST;
        end
        else if (wr_i)
        begin
            // Start bit is a strobe, never stored
            if (hit(addr_i, `FC_OFS_CTRL))
                ctrl_r <= {wr_data_i[`FC_CTRL_W-1:1], 1'b0};
            if (hit(addr_i, `FC_OFS_RATIO))
                ratio_r <= wr_data_i[`FC_RATIO_W-1:0];
            if (hit(addr_i, `FC_OFS_MASK))
                mask_r <= wr_data_i[`FC_ST_W-1:0];
        end
    end

    // ==========================================================
    // Sticky status: set wins over clear
    always @*
    begin
        status_nxt = status_r;
        if (wr_i && hit(addr_i, `FC_OFS_STATUS))
            status_nxt = status_nxt & ~wr_data_i[`FC_ST_W-1:0];
        // Reading the result retires the done flag
        if (rd_i && hit(addr_i, `FC_OFS_RESULT))
            status_nxt[`FC_ST_DONE] = 1'b0;
        if (latch_evt)
        begin
            status_nxt[`FC_ST_DONE] = 1'b1;
            // Previous result lost unread
            if (status_r[`FC_ST_DONE])
                status_nxt[`FC_ST_OVERRUN] = 1'b1;
        end
    end

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            status_r <= `FC_ST_RST;
            irq_o <= 1'b0;
            gate_o <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            irq_o <= |(status_nxt & mask_r);
            gate_o <= (state_nxt == ST_GATE);
        end
    end

    // ==========================================================
    // Read mux; unmapped offsets read zero
    assign rd_mux =
        hit(addr_i, `FC_OFS_CTRL) ?
            {23'h000000, state_r != ST_IDLE, ctrl_r} :
        hit(addr_i, `FC_OFS_RATIO) ? {2'h0, ratio_r} :
        hit(addr_i, `FC_OFS_RESULT) ? result_r[31:0] :
        hit(addr_i, `FC_OFS_STATUS) ? {30'h00000000, status_r} :
        hit(addr_i, `FC_OFS_MASK) ? {30'h00000000, mask_r} :
        32'h00000000;

    // Data stands only in the cycle after the strobe
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            rd_data_o <= 32'h00000000;
        else if (rd_i)
            rd_data_o <= rd_mux;
        else
            rd_data_o <= 32'h00000000;
    end

endmodule // fc_core

`default_nettype wire

/* File: sim/fc_core_asserts.sv */
// Purpose: Port checks of the counting core
// Assumes: One clock, async high reset
// Notes: Mirrors config at idle starts, and mask writes
`timescale 1ns/10ps
`default_nettype none
`include "fc_regs.vh"
module fc_chk #(
    parameter GATE_LONG_CYC = 50000000,
    parameter GATE_SHORT_CYC = 50000
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [`FC_ADDR_W-1:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rd_data_o,
    input wire logic burst_envelope_detector_i,
    input wire logic gate_o,
    input wire logic irq_o
);
logic [7:0] ctl_r;
logic [1:0] msk_r;
logic arm_r;
logic [31:0] len_r;
wire st_w = wr_i && addr_i == `FC_OFS_CTRL && wr_data_i[0];
wire dir_w = ctl_r[2:1] == 2'h0 && (ctl_r[3] ? !ctl_r[5] : !ctl_r[4]);
wire wid_w = ctl_r[2:1] == 2'h1;
// Config kept only at an idle start, though the core loads ctrl_r on every control write, busy or not
always @(posedge clk_sys_i or posedge rst_i)
begin
    if (rst_i)
    begin
        ctl_r <= 8'h00;
        msk_r <= 2'h0;
        arm_r <= 1'b0;
        len_r <= 32'h0;
    end
    else
    begin
        if (st_w && !arm_r)
            ctl_r <= wr_data_i[7:0];
        if (wr_i && addr_i == `FC_OFS_MASK)
            msk_r <= wr_data_i[1:0];
        if (st_w)
            arm_r <= 1'b1;
        else if (!gate_o && len_r != 32'h0)
            arm_r <= 1'b0;
        len_r <= gate_o ? len_r + 32'h1 : 32'h0;
    end
end
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (rst_i);
AST_RD_IDLE:
assert property (!$past(rd_i) |-> rd_data_o == 32'h0) else $error("idle rd");
AST_GATE_START:
assert property ($rose(gate_o) |-> arm_r) else $error("gate w/o start");
AST_SHORT:
assert property ($fell(gate_o) && dir_w && ctl_r[6] |->
    len_r == GATE_SHORT_CYC) else $error("short gate length");
AST_LONG:
assert property ($fell(gate_o) && dir_w && !ctl_r[6] |->
    len_r == GATE_LONG_CYC) else $error("long gate length");
AST_WID_OPEN:
assert property (wid_w && $past(arm_r, 2) && !gate_o &&
    $rose(burst_envelope_detector_i) |-> ##[0:2] gate_o)
    else $error("width gate not open");
AST_WID_CLOSE:
assert property (wid_w && gate_o && $fell(burst_envelope_detector_i)
    |-> ##[0:2] !gate_o) else $error("width gate not shut");
AST_IRQ_SET:
assert property ($fell(gate_o) && msk_r[0] |-> ##[0:2] irq_o)
    else $error("irq missing");
AST_IRQ_MASK:
assert property (msk_r == 2'h0 && $past(msk_r) == 2'h0 |-> !irq_o)
    else $error("masked irq");
AST_COV_DIR: cover property ($fell(gate_o) && dir_w);
AST_COV_WID: cover property ($fell(gate_o) && wid_w);
AST_COV_IRQ: cover property ($rose(irq_o));
endmodule // fc_chk
bind fc_core fc_chk #(.GATE_LONG_CYC(GATE_LONG_CYC),
    .GATE_SHORT_CYC(GATE_SHORT_CYC)) u_chk (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
    .rd_i(rd_i), .rd_data_o(rd_data_o), .gate_o(gate_o), .irq_o(irq_o),
    .burst_envelope_detector_i(burst_envelope_detector_i));
`default_nettype wire

/* File: sim/fc_cpu_model.sv */
// Purpose: Host processor bus model
// Assumes: One-cycle strobes, read data one cycle later
// Notes: Returns on a rising edge
`timescale 1ns/10ps
`default_nettype none
module fc_cpu_model (
    input wire logic clk_sys_i,
    output logic [4:0] addr_o,
    output logic [31:0] wr_data_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [31:0] rd_data_i
);
initial
begin
    addr_o = 5'h00;
    wr_data_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
end
// Spare edge after the strobe drops, so calls never collide
task automatic wr(input logic [4:0] a, input logic [31:0] d);
    addr_o <= a;
    wr_data_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    wr_data_o <= ~d; // Stale data never looks valid
    @(posedge clk_sys_i);
endtask
task automatic rd(input logic [4:0] a, output logic [31:0] d);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    // Data stands only this cycle; take it once settled, not on the edge
    #1;
    d = rd_data_i;
    @(posedge clk_sys_i);
endtask
// Host side of a microwave reading: harmonic times LO, IF folded in
function automatic logic [31:0] mw_freq(input logic [7:0] harm,
    input logic [31:0] lo, input logic [31:0] ifc, input logic below);
    mw_freq = below ? harm * lo - ifc : harm * lo + ifc;
endfunction
endmodule // fc_cpu_model
`default_nettype wire

/* File: sim/fc_core_test.sv */
// Purpose: Self-checking bench of the counting core
// Assumes: Gate lengths shortened to 200 and 20 cycles
// Notes: Inputs repeat every 180 cycles
`timescale 1ns/10ps
`default_nettype none
module fc_core_test;
logic clk_sys_i = 1'b0;
logic rst_i = 1'b1;
logic lb = 1'b0;
logic mw = 1'b0;
logic env = 1'b0;
logic [7:0] ph_r = 8'h00;
wire [4:0] addr;
wire [31:0] wd, rdat;
wire wr, rd, gate_o, irq_o;
int error_cnt = 0;
int compares = 0;
fc_core #(.GATE_LONG_CYC(200), .GATE_SHORT_CYC(20)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr),
    .wr_data_i(wd), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
    .low_band_input_i(lb), .microwave_input_i(mw),
    .burst_envelope_detector_i(env), .gate_o(gate_o), .irq_o(irq_o));
fc_cpu_model cpu (.clk_sys_i(clk_sys_i), .addr_o(addr), .wr_data_o(wd),
    .wr_o(wr), .rd_o(rd), .rd_data_i(rdat));
initial
begin
    forever #10 clk_sys_i = ~clk_sys_i;
end
// Low band every 5, IF every 4, bursts 3 high of 9
always @(posedge clk_sys_i)
begin
    ph_r <= (ph_r == 8'hb3) ? 8'h00 : ph_r + 8'h01;
    lb <= ph_r % 5 == 0;
    mw <= ph_r % 4 == 0;
    env <= ph_r % 9 < 3;
end
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
        error_cnt++;
        $display("FAIL %0t got %h exp %h", $time, g, e);
    end
endtask
task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    cpu.rd(a, d);
    chk(d, e);
endtask
// Start, wait for the interrupt, then read and retire the result
task automatic meas(input logic [31:0] c, input logic [31:0] e);
    cpu.wr(5'h00, c);
    repeat (600) if (irq_o !== 1'b1) @(posedge clk_sys_i);
    chk(irq_o, 32'h1);
    rdc(5'h08, e);
    rdc(5'h0c, 32'h0);
endtask
task automatic t_reset;
    rdc(5'h00, 32'h0);
    rdc(5'h04, 32'h2);
    rdc(5'h0c, 32'h0);
    rdc(5'h10, 32'h0);
    rdc(5'h14, 32'h0);
endtask
task automatic t_direct;
    cpu.wr(5'h10, 32'h1);
    meas(32'h41, 32'd4);
    rdc(5'h00, 32'h40);
    meas(32'h01, 32'd40);
    meas(32'h49, 32'd5);
    chk(cpu.mw_freq(8'd3, 32'd100, 32'd5, 1'b0), 32'd305);
    chk(cpu.mw_freq(8'd3, 32'd100, 32'd5, 1'b1), 32'd295);
endtask
task automatic t_recip;
    cpu.wr(5'h04, 32'h3);
    meas(32'h11, 32'd15);
    cpu.wr(5'h04, 32'h1);
    meas(32'h29, 32'd8);
endtask
task automatic t_burst;
    meas(32'h03, 32'd3);
    meas(32'h05, 32'd9);
    meas(32'h85, 32'd9);
endtask
// Unread result overrun, only overrun unmasked
task automatic t_overrun;
    cpu.wr(5'h10, 32'h2);
    cpu.wr(5'h00, 32'h03);
    repeat (40) @(posedge clk_sys_i);
    chk(irq_o, 32'h0);
    cpu.wr(5'h00, 32'h05);
    repeat (40) @(posedge clk_sys_i);
    chk(irq_o, 32'h1);
    rdc(5'h0c, 32'h3);
    rdc(5'h08, 32'd9);
    cpu.wr(5'h0c, 32'h3);
    rdc(5'h0c, 32'h0);
    chk(irq_o, 32'h0);
endtask
task print_verdict;
    if (error_cnt == 0 && compares > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
initial
begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset;
    t_direct;
    t_recip;
    t_burst;
    t_overrun;
    print_verdict;
end
// Ten runs of at most 600 cycles fit well inside this
initial
begin
    #300000;
    error_cnt++;
    print_verdict;
end
endmodule // fc_core_test
`default_nettype wire
